// ### sxa_pkg.sv
/*
 * constants, command encodings and state layout of the subtract, xor and
 * nibble-swap datapath.
 * assumes a single core clock and an apb master that drives the registers.
 */
package sxa_pkg;

	// ************************************************************
	// register offsets (byte addresses)
	// ************************************************************
	localparam logic [7:0] SXA_OFF_CMD = 8'h00;
	localparam logic [7:0] SXA_OFF_ACC = 8'h04;
	localparam logic [7:0] SXA_OFF_STAT = 8'h08;
	localparam logic [7:0] SXA_OFF_FADDR = 8'h0c;
	localparam logic [7:0] SXA_OFF_FDATA = 8'h10;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int SXA_CMD_LIT_LSB = 0;
	localparam int SXA_CMD_ADDR_LSB = 8;
	localparam int SXA_CMD_DEST_BIT = 16;
	localparam int SXA_CMD_OP_LSB = 24;
	localparam int SXA_STAT_CARRY_BIT = 0;
	localparam int SXA_STAT_NIB_BIT = 1;
	localparam int SXA_STAT_ZERO_BIT = 2;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] SXA_ACC_RST = 8'h00;
	localparam logic SXA_FLAG_RST = 1'b0;
	localparam logic [6:0] SXA_FADDR_RST = 7'h00;
	localparam logic [7:0] SXA_FMEM_RST = 8'h00;
	localparam logic [31:0] SXA_RDATA_RST = 32'h0000_0000;

	// ************************************************************
	// operations and state
	// ************************************************************
	typedef enum logic [2:0] {
		literal_minus_acc_op,
		reg_minus_acc_op,
		literal_xor_op,
		reg_xor_op,
		nibble_exchange_op
	} sxa_op_t;

	typedef struct packed {
		logic [127:0][7:0] fmem;
		logic [7:0] acc;
		logic carry;
		logic nibble_borrow_not_flag;
		logic zero;
		logic [6:0] faddr;
		logic [31:0] rdata;
	} sxa_state_t;

endpackage : sxa_pkg

// ### sxa_alu.sv
/*
 * apb-controlled datapath for literal/register minus the
 * accumulator, literal/register xor and register nibble swap, with the
 * accumulator, flags and a 128-byte register file held here.
 * assumes an apb master on clk_i; zero wait states, so pready is always high.
 */

// Behaviour
// - literal minus accumulator, two's complement
// - literal subtract always writes the accumulator
// - carry and nibble flag: accumulator not above literal
// - register minus accumulator, two's complement
// - carry and nibble flag: accumulator not above register
// - literal xor into accumulator, zero only
// - swap nibbles, flags untouched
// - swap destination bit picks target
// - register xor, destination bit, zero only
module sxa_alu
	import sxa_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// datapath state
	output logic [7:0] acc_o,
	output logic carry_o,
	output logic nibble_borrow_not_flag_o,
	output logic zero_o
);

	// ************************************************************
	// decode
	// ************************************************************
	sxa_state_t st_reg;
	sxa_state_t st_next;
	logic setup_w;
	logic access_w;
	logic mapped_w;
	logic op_ok_w;
	logic err_w;
	logic wr_w;
	logic exec_w;
	sxa_op_t op_w;
	logic [7:0] lit_w;
	logic [6:0] addr_w;
	logic dest_w;
	logic [7:0] src_w;
	logic [7:0] res_w;

	assign setup_w = psel_i & ~penable_i;
	assign access_w = psel_i & penable_i;
	assign op_w = sxa_op_t'(pwdata_i[SXA_CMD_OP_LSB +: 3]);
	assign lit_w = pwdata_i[SXA_CMD_LIT_LSB +: 8];
	assign addr_w = pwdata_i[SXA_CMD_ADDR_LSB +: 7];
	assign dest_w = pwdata_i[SXA_CMD_DEST_BIT];
	assign src_w = st_reg.fmem[addr_w];
	assign mapped_w = (paddr_i == SXA_OFF_CMD) || (paddr_i == SXA_OFF_ACC) ||
		(paddr_i == SXA_OFF_STAT) || (paddr_i == SXA_OFF_FADDR) ||
		(paddr_i == SXA_OFF_FDATA);
	// codes above the last operation are refused rather than run as a no-op
	assign op_ok_w = pwdata_i[SXA_CMD_OP_LSB +: 3] <= 3'(nibble_exchange_op);
	assign err_w = ~mapped_w |
		(pwrite_i & (paddr_i == SXA_OFF_CMD) & ~op_ok_w);
	assign wr_w = access_w & pwrite_i & ~err_w;
	assign exec_w = wr_w & (paddr_i == SXA_OFF_CMD);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		res_w = 8'h00;
		// read data is captured in setup so prdata comes from a flop
		if (setup_w & ~pwrite_i) begin
			case (paddr_i)
				SXA_OFF_ACC: st_next.rdata = {24'h000000, st_reg.acc};
				SXA_OFF_STAT: st_next.rdata = {29'h0, st_reg.zero,
					st_reg.nibble_borrow_not_flag, st_reg.carry};
				SXA_OFF_FADDR: st_next.rdata = {25'h0, st_reg.faddr};
				SXA_OFF_FDATA: st_next.rdata =
					{24'h000000, st_reg.fmem[st_reg.faddr]};
				default: st_next.rdata = SXA_RDATA_RST;
			endcase
		end
		if (wr_w) begin
			case (paddr_i)
				SXA_OFF_ACC: st_next.acc = pwdata_i[7:0];
				SXA_OFF_STAT: begin
					st_next.carry = pwdata_i[SXA_STAT_CARRY_BIT];
					st_next.nibble_borrow_not_flag = pwdata_i[SXA_STAT_NIB_BIT];
					st_next.zero = pwdata_i[SXA_STAT_ZERO_BIT];
				end
				SXA_OFF_FADDR: st_next.faddr = pwdata_i[6:0];
				SXA_OFF_FDATA: st_next.fmem[st_reg.faddr] = pwdata_i[7:0];
				default: ;
			endcase
		end
		if (exec_w) begin
			unique case (op_w)
				literal_minus_acc_op: begin
					res_w = lit_w - st_reg.acc;
					st_next.acc = res_w;
					st_next.carry = st_reg.acc <= lit_w;
					st_next.nibble_borrow_not_flag =
						st_reg.acc[3:0] <= lit_w[3:0];
					st_next.zero = res_w == 8'h00;
				end
				reg_minus_acc_op: begin
					res_w = src_w - st_reg.acc;
					st_next.carry = st_reg.acc <= src_w;
					st_next.nibble_borrow_not_flag =
						st_reg.acc[3:0] <= src_w[3:0];
					st_next.zero = res_w == 8'h00;
				end
				literal_xor_op: begin
					res_w = st_reg.acc ^ lit_w;
					st_next.acc = res_w;
					st_next.zero = res_w == 8'h00;
				end
				reg_xor_op: begin
					res_w = st_reg.acc ^ src_w;
					st_next.zero = res_w == 8'h00;
				end
				nibble_exchange_op: begin
					res_w = {src_w[3:0], src_w[7:4]};
				end
				default: ;
			endcase
			// shared destination select; literal ops never reach the file
			if (op_w == reg_minus_acc_op || op_w == reg_xor_op ||
				op_w == nibble_exchange_op) begin
				if (dest_w) begin
					st_next.fmem[addr_w] = res_w;
				end else begin
					st_next.acc = res_w;
				end
			end
		end
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_reg.fmem <= {128{SXA_FMEM_RST}};
			st_reg.acc <= SXA_ACC_RST;
			st_reg.carry <= SXA_FLAG_RST;
			st_reg.nibble_borrow_not_flag <= SXA_FLAG_RST;
			st_reg.zero <= SXA_FLAG_RST;
			st_reg.faddr <= SXA_FADDR_RST;
			st_reg.rdata <= SXA_RDATA_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign prdata_o = st_reg.rdata;
	assign pready_o = 1'b1;
	assign pslverr_o = access_w & err_w;
	assign acc_o = st_reg.acc;
	assign carry_o = st_reg.carry;
	assign nibble_borrow_not_flag_o = st_reg.nibble_borrow_not_flag;
	assign zero_o = st_reg.zero;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	property p_lit_sub_val;
		exec_w && op_w == literal_minus_acc_op |=>
			acc_o == 8'($past(lit_w) - $past(acc_o));
	endproperty
	a_lit_sub_val: assert property (p_lit_sub_val)
		else $error("literal subtract result wrong");

	property p_lit_sub_no_file;
		exec_w && op_w == literal_minus_acc_op |=>
			st_reg.fmem == $past(st_reg.fmem);
	endproperty
	a_lit_sub_no_file: assert property (p_lit_sub_no_file)
		else $error("literal subtract touched the file");

	property p_lit_sub_flags;
		exec_w && op_w == literal_minus_acc_op |=>
			carry_o == ($past(acc_o) <= $past(lit_w)) &&
			nibble_borrow_not_flag_o ==
				($past(acc_o[3:0]) <= $past(lit_w[3:0]));
	endproperty
	a_lit_sub_flags: assert property (p_lit_sub_flags)
		else $error("literal subtract flags wrong");

	property p_reg_sub_acc;
		exec_w && op_w == reg_minus_acc_op && !dest_w |=>
			acc_o == 8'($past(src_w) - $past(acc_o));
	endproperty
	a_reg_sub_acc: assert property (p_reg_sub_acc)
		else $error("register subtract to accumulator wrong");

	property p_reg_sub_file;
		exec_w && op_w == reg_minus_acc_op && dest_w |=>
			st_reg.fmem[$past(addr_w)] == 8'($past(src_w) - $past(acc_o)) &&
			$stable(acc_o);
	endproperty
	a_reg_sub_file: assert property (p_reg_sub_file)
		else $error("register subtract to file wrong");

	property p_reg_sub_flags;
		exec_w && op_w == reg_minus_acc_op |=>
			carry_o == ($past(acc_o) <= $past(src_w)) &&
			nibble_borrow_not_flag_o ==
				($past(acc_o[3:0]) <= $past(src_w[3:0]));
	endproperty
	a_reg_sub_flags: assert property (p_reg_sub_flags)
		else $error("register subtract flags wrong");

	property p_lit_xor;
		exec_w && op_w == literal_xor_op |=>
			acc_o == $past(acc_o ^ lit_w) && $stable(carry_o) &&
			$stable(nibble_borrow_not_flag_o);
	endproperty
	a_lit_xor: assert property (p_lit_xor)
		else $error("literal xor wrong");

	property p_swap_flags;
		exec_w && op_w == nibble_exchange_op |=>
			$stable({carry_o, nibble_borrow_not_flag_o, zero_o});
	endproperty
	a_swap_flags: assert property (p_swap_flags)
		else $error("swap altered a flag");

	property p_swap_file;
		exec_w && op_w == nibble_exchange_op && dest_w |=>
			st_reg.fmem[$past(addr_w)] ==
				{$past(src_w[3:0]), $past(src_w[7:4])} && $stable(acc_o);
	endproperty
	a_swap_file: assert property (p_swap_file)
		else $error("swap to file wrong");

	property p_reg_xor_acc;
		exec_w && op_w == reg_xor_op && !dest_w |=>
			acc_o == $past(acc_o ^ src_w) && $stable(carry_o) &&
			$stable(nibble_borrow_not_flag_o);
	endproperty
	a_reg_xor_acc: assert property (p_reg_xor_acc)
		else $error("register xor wrong");

	property p_zero;
		exec_w && op_w != nibble_exchange_op |=>
			zero_o == ($past(res_w) == 8'h00);
	endproperty
	a_zero: assert property (p_zero)
		else $error("zero flag wrong");

	c_lit_borrow: cover property (exec_w && op_w == literal_minus_acc_op &&
		acc_o > lit_w);
	c_reg_sub_file: cover property (exec_w && op_w == reg_minus_acc_op &&
		dest_w);
	c_swap_acc: cover property (exec_w && op_w == nibble_exchange_op &&
		!dest_w);
	c_xor_zero: cover property (exec_w && op_w == reg_xor_op &&
		src_w == acc_o);

endmodule : sxa_alu

// ### test_subtract_xor_swap_alu_ops.sv
/*
 * self-checking bench for sxa_alu: the five operations in turn on random operands against an integer
 * and queue model of accumulator, flags and register file.
 * assumes zero-wait apb slave and no other masters on the bus.
 */
module test_subtract_xor_swap_alu_ops
	import sxa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// design hookup
	// ************************************************************
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0000_0000;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o;
	logic [7:0] acc_o;
	logic carry_o, nibble_borrow_not_flag_o, zero_o;
	int mismatches = 0;
	int num_checks = 0;

	sxa_alu sxa_alu_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .acc_o(acc_o), .carry_o(carry_o),
		.nibble_borrow_not_flag_o(nibble_borrow_not_flag_o),
		.zero_o(zero_o));

	always #50 clk_i = ~clk_i;

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// no cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		r = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		#1;
	endtask : apb

	initial begin
		#1_000_000;
		mismatches++;
		print_verdict();
	end

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		int fm [$];
		logic [7:0] acc, k, f, res, a;
		logic [6:0] ad;
		logic [2:0] st;
		logic c, nb, z, d, e;
		logic [31:0] r;
		int op;
		void'($urandom(62));
		repeat (128) begin
			fm.push_back(0);
		end
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		#1;
		chk({acc_o, carry_o, nibble_borrow_not_flag_o, zero_o}, 32'h0);
		for (int i = 0; i < 60; i++) begin
			op = i % 5;
			{k, a, f, ad, d, st} = 35'({$urandom, $urandom});
			if (i % 6 == 0) k = a;
			// equal operands give a zero result for register subtract and xor
			if (i % 10 == 1 || i % 10 == 8) f = a;
			apb(1'b1, SXA_OFF_ACC, {24'h0, a}, r, e);
			apb(1'b1, SXA_OFF_STAT, {29'h0, st}, r, e);
			apb(1'b1, SXA_OFF_FADDR, {25'h0, ad}, r, e);
			apb(1'b1, SXA_OFF_FDATA, {24'h0, f}, r, e);
			acc = a;
			{z, nb, c} = st;
			fm[ad] = f;
			case (op)
				0: res = k - acc;
				1: res = f - acc;
				2: res = acc ^ k;
				3: res = acc ^ f;
				default: res = {f[3:0], f[7:4]};
			endcase
			if (op < 2) begin
				c = (acc <= (op == 0 ? k : f));
				nb = (acc[3:0] <= (op == 0 ? k[3:0] : f[3:0]));
			end
			if (op < 4) z = (res == 8'h00);
			if (op == 0 || op == 2 || !d) acc = res;
			else fm[ad] = res;
			apb(1'b1, SXA_OFF_CMD, {5'h0, 3'(op), 7'h0, d, 1'b0, ad, k}, r, e);
			chk(e, 1'b0);
			chk(acc_o, acc);
			chk({zero_o, nibble_borrow_not_flag_o, carry_o}, {z, nb, c});
			apb(1'b0, SXA_OFF_FDATA, 32'h0, r, e);
			chk(r, fm[ad]);
		end
		// undefined operation codes 5 to 7 are refused
		for (int j = 5; j < 8; j++) begin
			apb(1'b1, SXA_OFF_CMD, {5'h0, 3'(j), 24'h0100ff}, r, e);
			chk(e, 1'b1);
			chk(acc_o, acc);
			chk({zero_o, nibble_borrow_not_flag_o, carry_o}, {z, nb, c});
		end
		// read-back of stat, faddr, acc and cmd; cmd reads zero after a non-zero; an unmapped address is refused
		apb(1'b0, SXA_OFF_STAT, 32'h0, r, e);
		chk(r, {29'h0, z, nb, c});
		apb(1'b0, SXA_OFF_FADDR, 32'h0, r, e);
		chk(r, {25'h0, ad});
		apb(1'b1, SXA_OFF_ACC, 32'h0000_005a, r, e);
		apb(1'b0, SXA_OFF_ACC, 32'h0, r, e);
		chk(r, 32'h0000_005a);
		apb(1'b0, SXA_OFF_CMD, 32'h0, r, e);
		chk(r, 32'h0);
		chk(e, 1'b0);
		apb(1'b0, SXA_OFF_ACC, 32'h0, r, e);
		chk(r, 32'h0000_005a);
		apb(1'b0, 8'h14, 32'h0, r, e);
		chk(r, 32'h0);
		chk(e, 1'b1);
		print_verdict();
	end
endmodule : test_subtract_xor_swap_alu_ops
